// >>> rtl/uftas_pkg.sv
// constants shared by the fifo test-access and status block
package uftas_pkg;
    localparam int unsigned APB_AW = 32;
    localparam int unsigned APB_DW = 32;
    // register byte addresses
    localparam logic [APB_AW-1:0] FTAC_ADDR = 32'h5000_1170;
    localparam logic [APB_AW-1:0] STAT_ADDR = 32'h5000_117c;
    localparam logic [APB_AW-1:0] DATA_ADDR = 32'h5000_1100;
    localparam logic [APB_AW-1:0] FCR_ADDR = 32'h5000_1108;
    localparam logic [APB_AW-1:0] IRQ_STAT_ADDR = 32'h5000_1180;
    localparam logic [APB_AW-1:0] IRQ_CLR_ADDR = 32'h5000_1184;
    localparam logic [APB_AW-1:0] IRQ_EN_ADDR = 32'h5000_1188;
    // field positions
    localparam int unsigned FTAE_BIT = 0;
    localparam int unsigned FEN_BIT = 0;
    localparam int unsigned RQF_BIT = 4;
    localparam int unsigned RQNE_BIT = 3;
    localparam int unsigned TQE_BIT = 2;
    localparam int unsigned TQNF_BIT = 1;
    localparam int unsigned STAT_W = 16;
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_RX_FULL = 0;
    localparam int unsigned IRQ_RX_DATA = 1;
    localparam int unsigned IRQ_TOGGLE = 2;
    // reset values
    localparam logic FTAE_RST = 1'b0;
    localparam logic FEN_RST = 1'b0;
    localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
    // character width and defaults of the top-level parameters
    localparam int unsigned CHAR_W = 8;
    localparam int unsigned QUEUE_DEPTH = 16;
    localparam bit FIFO_ACCESS_DFLT = 1'b1;
endpackage

// >>> rtl/uftas_mem.sv
// queue storage with write-first registered read port
`timescale 1ns/100ps
module uftas_mem #(
    parameter int unsigned W = 8,
    parameter int unsigned DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic we_i,
    input wire logic [$clog2(DEPTH)-1:0] waddr_i,
    input wire logic [W-1:0] wdata_i,
    input wire logic [$clog2(DEPTH)-1:0] raddr_i,
    output logic [W-1:0] rdata_o
);
    logic [W-1:0] mem_r [DEPTH];
    logic [W-1:0] rdata_r;

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_r[waddr_i] <= wdata_i;
        end
    end

    // a write to the word being fetched is passed straight to the head
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_r <= '0;
        end else if (we_i && waddr_i == raddr_i) begin
            rdata_r <= wdata_i;
        end else begin
            rdata_r <= mem_r[raddr_i];
        end
    end

    assign rdata_o = rdata_r;
endmodule

// >>> rtl/uftas_top.sv
// uart queue test access, queue status and apb register slave
`timescale 1ns/100ps
// Notes on behaviour
// - without the test-access option, writes to the enable bit are ignored; always readable
// - test access with queues on: bus writes fill rx queue, reads drain tx queue
// - test access with queues off: bus writes load rx buffer, reads return tx holding
// - switching test access on or off empties both queues
// - test-access enable is bit 0, resets to zero, one enables
// - status bit 4 reads one while the rx queue is full, resets zero
// - status bit 3 reads one while rx queue holds an entry, resets zero
// - rx not-empty bit clears once the last entry leaves
// - queues are used only when control bit 0 is one; else single buffers
module uftas_top #(
    parameter int unsigned DEPTH = uftas_pkg::QUEUE_DEPTH,
    parameter bit FIFO_ACCESS = uftas_pkg::FIFO_ACCESS_DFLT
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [uftas_pkg::APB_AW-1:0] paddr_i,
    input wire logic [uftas_pkg::APB_DW-1:0] pwdata_i,
    output logic [uftas_pkg::APB_DW-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic rx_push_i,
    input wire logic [uftas_pkg::CHAR_W-1:0] rx_data_i,
    input wire logic tx_pop_i,
    output logic tx_valid_o,
    output logic [uftas_pkg::CHAR_W-1:0] tx_data_o,
    output logic fifo_en_o,
    output logic test_access_o,
    output logic irq_o
);
    import uftas_pkg::*;

    localparam int unsigned PW = $clog2(DEPTH);
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam int RX = 0;
    localparam int TX = 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("uftas_top: DEPTH must be a power of two, at least 2");
    end

    logic ftae_r, fen_r;
    logic [CHAR_W-1:0] rbr_r;
    logic rbr_v_r;
    logic [CHAR_W-1:0] thr_r;
    logic thr_v_r;
    logic [APB_DW-1:0] prdata_r;
    logic rd_ok_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_en_r;
    logic rq_full_prev_r, rq_ne_prev_r;
    logic [CW-1:0] cnt_r [2];
    logic [PW-1:0] wp_r [2];
    logic [PW-1:0] rp_r [2];
    logic [CHAR_W-1:0] head [2];
    logic push [2], pop [2];
    logic [CHAR_W-1:0] wdata [2];

    // apb decode; the slave never inserts wait states
    logic setup, commit, wr, rd, mapped;
    logic hit_ftac, hit_stat, hit_data, hit_fcr, hit_ist, hit_icl, hit_ien;
    assign setup = psel_i & ~penable_i;
    assign commit = psel_i & penable_i;
    assign wr = commit & pwrite_i;
    assign rd = commit & ~pwrite_i;
    assign hit_ftac = paddr_i == FTAC_ADDR;
    assign hit_stat = paddr_i == STAT_ADDR;
    assign hit_data = paddr_i == DATA_ADDR;
    assign hit_fcr = paddr_i == FCR_ADDR;
    assign hit_ist = paddr_i == IRQ_STAT_ADDR;
    assign hit_icl = paddr_i == IRQ_CLR_ADDR;
    assign hit_ien = paddr_i == IRQ_EN_ADDR;
    assign mapped = hit_ftac | hit_stat | hit_data | hit_fcr | hit_ist | hit_icl | hit_ien;
    assign pready_o = 1'b1;
    assign pslverr_o = commit & ~mapped;
    assign prdata_o = prdata_r;

    // queue and buffer status
    logic rq_full, rq_ne, tq_empty, tq_nfull;
    logic [STAT_W-1:0] status;
    assign rq_full = fen_r ? (cnt_r[RX] == FULL_CNT) : rbr_v_r;
    assign rq_ne = fen_r ? (cnt_r[RX] != '0) : rbr_v_r;
    assign tq_empty = fen_r ? (cnt_r[TX] == '0) : ~thr_v_r;
    assign tq_nfull = fen_r ? (cnt_r[TX] != FULL_CNT) : ~thr_v_r;
    always_comb begin
        status = '0;
        status[RQF_BIT] = rq_full;
        status[RQNE_BIT] = rq_ne;
        status[TQE_BIT] = tq_empty;
        status[TQNF_BIT] = tq_nfull;
    end

    // test-access enable: a change of value is what empties the queues
    logic ftae_wr, ftae_flip;
    assign ftae_wr = wr & hit_ftac & FIFO_ACCESS;
    assign ftae_flip = ftae_wr & (pwdata_i[FTAE_BIT] != ftae_r);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ftae_r <= FTAE_RST;
        end else if (ftae_wr) begin
            ftae_r <= pwdata_i[FTAE_BIT];
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fen_r <= FEN_RST;
        end else if (wr && hit_fcr) begin
            fen_r <= pwdata_i[FEN_BIT];
        end
    end

    // data register traffic; rd_ok_r guards a pop against an empty source
    logic bus_wd, bus_rd, rx_eng;
    assign bus_wd = wr & hit_data;
    assign bus_rd = rd & hit_data & rd_ok_r;
    assign rx_eng = rx_push_i & ~(ftae_r & bus_wd);

    always_comb begin
        push[RX] = 1'b0;
        pop[RX] = 1'b0;
        push[TX] = 1'b0;
        pop[TX] = 1'b0;
        wdata[RX] = rx_data_i;
        wdata[TX] = pwdata_i[CHAR_W-1:0];
        if (fen_r && !ftae_flip) begin
            if (ftae_r && bus_wd && !rq_full) begin
                push[RX] = 1'b1;
                wdata[RX] = pwdata_i[CHAR_W-1:0];
            end else if (rx_eng && !rq_full) begin
                push[RX] = 1'b1;
            end
            pop[RX] = bus_rd & ~ftae_r;
            push[TX] = bus_wd & ~ftae_r & tq_nfull;
            if (ftae_r && bus_rd) begin
                pop[TX] = 1'b1;
            end else begin
                pop[TX] = tx_pop_i & ~tq_empty;
            end
        end
    end

    // one queue control per direction; storage lives in the memory module
    generate
        for (genvar q = 0; q < 2; q++) begin : g_queue
            logic [PW-1:0] rp_nxt;
            logic [PW-1:0] raddr;
            assign rp_nxt = rp_r[q] + PW'(1);
            assign raddr = ftae_flip ? '0 : (pop[q] ? rp_nxt : rp_r[q]);

            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    cnt_r[q] <= '0;
                    wp_r[q] <= '0;
                    rp_r[q] <= '0;
                end else if (ftae_flip) begin
                    cnt_r[q] <= '0;
                    wp_r[q] <= '0;
                    rp_r[q] <= '0;
                end else begin
                    if (push[q]) begin
                        wp_r[q] <= wp_r[q] + PW'(1);
                    end
                    if (pop[q]) begin
                        rp_r[q] <= rp_nxt;
                    end
                    if (push[q] && !pop[q]) begin
                        cnt_r[q] <= cnt_r[q] + CW'(1);
                    end else if (pop[q] && !push[q]) begin
                        cnt_r[q] <= cnt_r[q] - CW'(1);
                    end
                end
            end

            uftas_mem #(
                .W(CHAR_W),
                .DEPTH(DEPTH)
            ) u_mem (
                .clk_i(clk_i),
                .rstn_i(rstn_i),
                .we_i(push[q]),
                .waddr_i(wp_r[q]),
                .wdata_i(wdata[q]),
                .raddr_i(raddr),
                .rdata_o(head[q])
            );
        end
    endgenerate

    // single-entry buffers used while the queues are off
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rbr_r <= '0;
            rbr_v_r <= 1'b0;
        end else if (ftae_flip) begin
            rbr_v_r <= 1'b0;
        end else if (!fen_r) begin
            if (ftae_r && bus_wd) begin
                rbr_r <= pwdata_i[CHAR_W-1:0];
                rbr_v_r <= 1'b1;
            end else if (rx_eng) begin
                rbr_r <= rx_data_i;
                rbr_v_r <= 1'b1;
            end else if (bus_rd && !ftae_r) begin
                rbr_v_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            thr_r <= '0;
            thr_v_r <= 1'b0;
        end else if (ftae_flip) begin
            thr_v_r <= 1'b0;
        end else if (!fen_r) begin
            if (bus_wd && !ftae_r) begin
                thr_r <= pwdata_i[CHAR_W-1:0];
                thr_v_r <= 1'b1;
            end else if (tx_pop_i && thr_v_r) begin
                thr_v_r <= 1'b0;
            end
        end
    end

    assign tx_valid_o = ~tq_empty;
    assign tx_data_o = fen_r ? head[TX] : thr_r;
    assign fifo_en_o = fen_r;
    assign test_access_o = ftae_r;

    // read data is fetched in the setup cycle and held through the access
    logic [CHAR_W-1:0] data_rd;
    logic data_ok;
    always_comb begin
        if (ftae_r) begin
            data_rd = fen_r ? head[TX] : thr_r;
            data_ok = fen_r ? ~tq_empty : 1'b0;
        end else begin
            data_rd = fen_r ? head[RX] : rbr_r;
            data_ok = rq_ne;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_r <= '0;
            rd_ok_r <= 1'b0;
        end else if (setup) begin
            rd_ok_r <= ~pwrite_i & hit_data & data_ok;
            prdata_r <= '0;
            if (!pwrite_i) begin
                if (hit_ftac) begin
                    prdata_r <= APB_DW'(ftae_r);
                end else if (hit_stat) begin
                    prdata_r <= APB_DW'(status);
                end else if (hit_data) begin
                    prdata_r <= APB_DW'(data_rd);
                end else if (hit_fcr) begin
                    prdata_r <= APB_DW'(fen_r);
                end else if (hit_ist) begin
                    prdata_r <= APB_DW'(irq_stat_r);
                end else if (hit_ien) begin
                    prdata_r <= APB_DW'(irq_en_r);
                end
            end
        end
    end

    // sticky events; a new event beats a clear in the same cycle
    logic [IRQ_W-1:0] ev;
    assign ev[IRQ_RX_FULL] = rq_full & ~rq_full_prev_r;
    assign ev[IRQ_RX_DATA] = rq_ne & ~rq_ne_prev_r;
    assign ev[IRQ_TOGGLE] = ftae_flip;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rq_full_prev_r <= 1'b0;
            rq_ne_prev_r <= 1'b0;
            irq_stat_r <= IRQ_RST;
            irq_en_r <= IRQ_RST;
        end else begin
            rq_full_prev_r <= rq_full;
            rq_ne_prev_r <= rq_ne;
            if (wr && hit_icl) begin
                irq_stat_r <= (irq_stat_r & ~pwdata_i[IRQ_W-1:0]) | ev;
            end else begin
                irq_stat_r <= irq_stat_r | ev;
            end
            if (wr && hit_ien) begin
                irq_en_r <= pwdata_i[IRQ_W-1:0];
            end
        end
    end

    assign irq_o = |(irq_stat_r & irq_en_r);

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    chk_far_locked: assert property (FIFO_ACCESS == 1'b0 |-> ftae_r == 1'b0)
        else $error("test-access bit moved without the option");
    chk_far_store: assert property (wr && hit_ftac && FIFO_ACCESS |=> ftae_r == $past(pwdata_i[0]))
        else $error("test-access bit not written");
    chk_rx_bus_fill: assert property (wr && hit_data && ftae_r && fen_r && !rq_full
        && !ftae_flip |=> cnt_r[RX] == $past(cnt_r[RX]) + 1)
        else $error("bus write did not fill rx queue");
    chk_rbr_load: assert property (wr && hit_data && ftae_r && !fen_r
        |=> rbr_v_r && rbr_r == $past(pwdata_i[7:0]))
        else $error("bus write did not load rx buffer");
    chk_thr_readback: assert property (setup && !pwrite_i && hit_data && ftae_r
        && !fen_r |=> prdata_r[7:0] == $past(thr_r) ##1 thr_v_r == $past(thr_v_r, 2))
        else $error("tx holding readback wrong");
    chk_toggle_empty: assert property (ftae_flip |=> cnt_r[RX] == 0 && cnt_r[TX] == 0
        && !rbr_v_r && !thr_v_r && !status[3])
        else $error("queues not emptied on toggle");
    chk_rx_full_flag: assert property (fen_r && cnt_r[RX] == FULL_CNT |-> status[4])
        else $error("rx full flag missing");
    chk_rx_ne_flag: assert property (push[RX] && !ftae_flip |=> status[3])
        else $error("rx not-empty flag missing after push");
    chk_rx_last_out: assert property (fen_r && cnt_r[RX] == 1 && pop[RX]
        && !push[RX] |=> !status[3] && !status[4])
        else $error("rx not-empty flag stuck after last pop");
    chk_mode_off: assert property (!fen_r |-> !push[RX] && !push[TX] && !pop[TX])
        else $error("queue used while disabled");
    chk_stat_reserved: assert property (setup && !pwrite_i && hit_stat
        |=> prdata_r[31:5] == 0 && prdata_r[0] == 1'b0)
        else $error("reserved status bits not zero");
endmodule

// >>> testbench/uftas_engine_model.sv
// behavioural model of the receive and transmit engines beside the block
`timescale 1ns/100ps
module uftas_engine_model (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic rx_go_i,
    input wire logic fast_i,
    input wire logic tx_take_i,
    input wire logic tx_valid_i,
    output logic rx_push_o,
    output logic [7:0] rx_data_o,
    output logic tx_pop_o
);
    logic [7:0] next_char_r;
    // between pushes the char lines toggle each cycle, starting with the inverse of the last char
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_push_o <= 1'b0;
            rx_data_o <= 8'h00;
            next_char_r <= 8'h41;
        end else if (rx_go_i && (fast_i || !rx_push_o)) begin
            rx_push_o <= 1'b1;
            rx_data_o <= next_char_r;
            next_char_r <= next_char_r + 8'h01;
        end else begin
            rx_push_o <= 1'b0;
            rx_data_o <= ~rx_data_o;
        end
    end
    // slow mode leaves a gap cycle after every take
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_pop_o <= 1'b0;
        end else begin
            tx_pop_o <= tx_take_i && tx_valid_i && (fast_i || !tx_pop_o);
        end
    end
endmodule

// >>> testbench/tb_uart_fifo_test_access_status.sv
// self-checking bench for the queue test-access and status block
`timescale 1ns/100ps
module tb_uart_fifo_test_access_status;
    import uftas_pkg::*;
    localparam int unsigned DEPTH = 4;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, rx_push, tx_pop, tx_valid, fifo_en, test_access, irq;
    logic [7:0] rx_data, tx_data;
    logic ta_locked;
    logic rx_go = 1'b0;
    logic fast = 1'b0;
    logic tx_take = 1'b0;
    logic [7:0] seed = 8'h4b;
    logic [32:0] expq[$];
    logic [7:0] rxq[$];
    logic [7:0] txq[$];
    int err_total = 0;
    int n_checks = 0;
    int i;

    uftas_top #(.DEPTH(DEPTH), .FIFO_ACCESS(1'b1)) u_dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .rx_push_i(rx_push),
        .rx_data_i(rx_data), .tx_pop_i(tx_pop), .tx_valid_o(tx_valid),
        .tx_data_o(tx_data), .fifo_en_o(fifo_en), .test_access_o(test_access),
        .irq_o(irq));
    // a second block built without the test-access option shares the bus
    uftas_top #(.DEPTH(DEPTH), .FIFO_ACCESS(1'b0)) u_dut_locked (
        .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(),
        .pready_o(), .pslverr_o(), .rx_push_i(rx_push),
        .rx_data_i(rx_data), .tx_pop_i(tx_pop), .tx_valid_o(),
        .tx_data_o(), .fifo_en_o(), .test_access_o(ta_locked),
        .irq_o());
    uftas_engine_model u_eng (
        .clk_i(clk_i), .rstn_i(rstn_i), .rx_go_i(rx_go), .fast_i(fast),
        .tx_take_i(tx_take), .tx_valid_i(tx_valid), .rx_push_o(rx_push),
        .rx_data_o(rx_data), .tx_pop_o(tx_pop));

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic give_up();
        err_total++;
        complete_run();
    endtask

    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_tx(input logic [7:0] got, input logic [7:0] exp);
        cmp({25'h0, got}, {25'h0, exp});
    endtask

    task automatic cmp_pin(input logic got, input logic exp);
        cmp({32'h0, got}, {32'h0, exp});
    endtask

    // one apb transfer; a read notes its expected {pslverr, prdata}
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic [32:0] exp);
        int n;
        if (!w) expq.push_back(exp);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 64);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 64) give_up();
        @(posedge clk_i);
    endtask

    task automatic tx_write();
        seed = lfsr(seed);
        txq.push_back(seed);
        apb(1'b1, DATA_ADDR, {24'h0, seed}, 33'h0);
    endtask

    task automatic tx_drain();
        for (i = 0; i < 200 && txq.size() > 0; i++) @(posedge clk_i);
        if (txq.size() > 0) give_up();
    endtask

    // result watcher: read data, tx chars, and the model of the rx queue
    always @(posedge clk_i) begin
        if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) begin
            cmp({pslverr, prdata}, expq.pop_front());
        end
        if (tx_pop && tx_valid === 1'b1 && txq.size() > 0) begin
            cmp_tx(tx_data, txq.pop_front());
        end
        if (rx_push && test_access === 1'b0 && rxq.size() < DEPTH) begin
            rxq.push_back(rx_data);
        end
    end

    initial begin
        for (i = 0; i < 12; i++) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        apb(1'b0, FTAC_ADDR, 32'h0, 33'h0);
        apb(1'b0, STAT_ADDR, 32'h0, 33'h6);
        apb(1'b1, 32'h5000_1190, 32'h1, 33'h0);
        apb(1'b0, 32'h5000_1190, 32'h0, 33'h1_0000_0000);
        apb(1'b0, IRQ_EN_ADDR, 32'h0, 33'h0);
        $display("test reset values done");
        apb(1'b1, FCR_ADDR, 32'h1, 33'h0);
        cmp_pin(fifo_en, 1'b1);
        apb(1'b1, IRQ_EN_ADDR, 32'h1, 33'h0);
        rx_go <= 1'b1;
        for (i = 0; i < 200 && rxq.size() < DEPTH; i++) @(posedge clk_i);
        if (rxq.size() < DEPTH) give_up();
        repeat (4) @(posedge clk_i);
        rx_go <= 1'b0;
        repeat (3) @(posedge clk_i);
        cmp_pin(irq, 1'b1);
        apb(1'b0, STAT_ADDR, 32'h0, 33'h1e);
        apb(1'b0, IRQ_STAT_ADDR, 32'h0, 33'h3);
        apb(1'b1, IRQ_EN_ADDR, 32'h0, 33'h0);
        cmp_pin(irq, 1'b0);
        apb(1'b1, IRQ_CLR_ADDR, 32'h7, 33'h0);
        apb(1'b0, IRQ_STAT_ADDR, 32'h0, 33'h0);
        apb(1'b0, DATA_ADDR, 32'h0, {25'h0, rxq.pop_front()});
        apb(1'b0, STAT_ADDR, 32'h0, 33'he);
        while (rxq.size() > 0) apb(1'b0, DATA_ADDR, 32'h0, {25'h0, rxq.pop_front()});
        apb(1'b0, STAT_ADDR, 32'h0, 33'h6);
        $display("test rx queue fill and drain done");
        fast <= 1'b1;
        tx_take <= 1'b1;
        for (int k = 0; k < 3; k++) tx_write();
        tx_drain();
        tx_take <= 1'b0;
        $display("test tx queue done");
        tx_write();
        tx_write();
        apb(1'b0, STAT_ADDR, 32'h0, 33'h2);
        apb(1'b1, FTAC_ADDR, 32'h1, 33'h0);
        txq.delete();
        cmp_pin(tx_valid, 1'b0);
        cmp_pin(test_access, 1'b1);
        cmp_pin(ta_locked, 1'b0);
        apb(1'b0, FTAC_ADDR, 32'h0, 33'h1);
        apb(1'b0, STAT_ADDR, 32'h0, 33'h6);
        for (int k = 0; k < DEPTH; k++) begin
            seed = lfsr(seed);
            apb(1'b1, DATA_ADDR, {24'h0, seed}, 33'h0);
        end
        apb(1'b0, STAT_ADDR, 32'h0, 33'h1e);
        apb(1'b1, FTAC_ADDR, 32'h0, 33'h0);
        apb(1'b0, STAT_ADDR, 32'h0, 33'h6);
        $display("test access toggle done");
        apb(1'b1, FCR_ADDR, 32'h0, 33'h0);
        apb(1'b1, FTAC_ADDR, 32'h1, 33'h0);
        apb(1'b1, DATA_ADDR, 32'h5a, 33'h0);
        apb(1'b0, STAT_ADDR, 32'h0, 33'h1e);
        apb(1'b1, FTAC_ADDR, 32'h0, 33'h0);
        fast <= 1'b0;
        tx_take <= 1'b1;
        tx_write();
        tx_drain();
        apb(1'b1, FTAC_ADDR, 32'h1, 33'h0);
        apb(1'b0, DATA_ADDR, 32'h0, {25'h0, seed});
        apb(1'b1, STAT_ADDR, 32'hffff_ffff, 33'h0);
        apb(1'b0, STAT_ADDR, 32'h0, 33'h6);
        $display("test single buffers done");
        complete_run();
    end
endmodule
